// file: hdl/blsc_pkg.sv
// Shared constants and types of the button and LED state controller.
package blsc_pkg;

    // Clock and the one-millisecond timing tick.
    localparam int CLK_PERIOD_NS      = 4;
    localparam int TICK_PERIOD_US     = 1000;
    localparam int TICK_CYCLES        = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

    // Times in their own units and as counts of ticks.
    localparam int AUTO_OFF_MIN       = 15;
    localparam int AUTO_OFF_TICKS     = AUTO_OFF_MIN * 60 * 1000000 / TICK_PERIOD_US;
    localparam int HOLD_RESET_S       = 12;
    localparam int HOLD_TICKS         = HOLD_RESET_S * 1000000 / TICK_PERIOD_US;
    localparam int GAP_MS             = 400;
    localparam int GAP_TICKS          = GAP_MS * 1000 / TICK_PERIOD_US;
    localparam int BOOT_TIMEOUT_S     = 30;
    localparam int BOOT_TIMEOUT_TICKS = BOOT_TIMEOUT_S * 1000000 / TICK_PERIOD_US;

    // Blink patterns, in ticks of the blink phase counter.
    localparam logic [11:0] PHASE_PERIOD = 12'hFA0;
    localparam logic [11:0] RAPID_PERIOD = 12'h064;
    localparam logic [11:0] RAPID_ON     = 12'h032;
    localparam logic [11:0] SLOW_PERIOD  = 12'h1F4;
    localparam logic [11:0] SLOW_ON      = 12'h0FA;
    localparam logic [11:0] VSLOW_ON     = 12'h0C8;
    localparam logic [11:0] BURST_SPAN   = 12'h7D0;
    localparam logic [11:0] BURST_PERIOD = 12'h190;
    localparam logic [11:0] BURST_ON     = 12'h0C8;

    // Press counts of the gestures.
    localparam logic [2:0] CNT_SINGLE = 3'h1;
    localparam logic [2:0] CNT_TRIPLE = 3'h3;
    localparam logic [2:0] CNT_PAIR   = 3'h5;
    localparam logic [2:0] CNT_MAX    = 3'h7;

    typedef enum logic [2:0] {
        ST_OFF     = 3'h0,
        ST_BOOT    = 3'h1,
        ST_SEARCH  = 3'h3,
        ST_ENABLED = 3'h2,
        ST_PAUSED  = 3'h6,
        ST_PAIRING = 3'h7,
        ST_ERROR   = 3'h5
    } blsc_state_t;

endpackage

// file: hdl/blsc_gest_if.sv
// Gesture events passed from the press decoder to the state controller.
`timescale 1ns/1ps
interface blsc_gest_if;
    logic [2:0] count;
    logic       valid;
    logic       hold_release;

    modport src (output count, output valid, output hold_release);
    modport dst (input count, input valid, input hold_release);
endinterface

// file: hdl/blsc_gesture.sv
// Pushbutton decoder: groups presses into multi-press gestures and detects a long hold.
`timescale 1ns/1ps
module blsc_gesture #(
    parameter int HOLD_TICKS = blsc_pkg::HOLD_TICKS,
    parameter int GAP_TICKS  = blsc_pkg::GAP_TICKS
) (
    input wire logic    sys_clk,
    input wire logic    rst_n,
    input wire logic    tick,
    input wire logic    btn,
    blsc_gest_if.src    gest
);
    localparam int HW = $clog2(HOLD_TICKS + 1);
    localparam int GW = $clog2(GAP_TICKS + 1);

    if (HOLD_TICKS < 2 || GAP_TICKS < 2)
    begin : g_check
        $error("blsc_gesture: hold and gap counts must be at least two ticks");
    end

    logic          btn_q;
    logic [2:0]    cnt_q;
    logic [GW-1:0] gap_q;
    logic [HW-1:0] held_q;
    logic          valid_q;
    logic          hold_q;
    logic [2:0]    count_q;

    wire press    = btn && !btn_q;
    wire release_ = !btn && btn_q;
    wire is_long  = (held_q == HW'(HOLD_TICKS));
    wire gap_done = (cnt_q != 3'h0) && !btn && tick && (gap_q == GW'(GAP_TICKS - 1));

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            btn_q <= 1'b0;
        else
            btn_q <= btn;
    end

    // Hold time saturates so that any hold beyond the limit still counts.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            held_q <= '0;
        else if (press)
            held_q <= '0;
        else if (btn && tick && !is_long)
            held_q <= held_q + HW'(1);
    end

    // The quiet time after the last release closes the gesture.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            gap_q <= '0;
        else if (btn || gap_done)
            gap_q <= '0;
        else if (tick && cnt_q != 3'h0)
            gap_q <= gap_q + GW'(1);
    end

    // A long hold cancels the presses gathered so far.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 3'h0;
        else if ((release_ && is_long) || gap_done)
            cnt_q <= 3'h0;
        else if (press && cnt_q != blsc_pkg::CNT_MAX)
            cnt_q <= cnt_q + 3'h1;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_q <= 1'b0;
            count_q <= 3'h0;
            hold_q  <= 1'b0;
        end
        else
        begin
            valid_q <= gap_done;
            count_q <= gap_done ? cnt_q : 3'h0;
            hold_q  <= release_ && is_long;
        end
    end

    assign gest.valid        = valid_q;
    assign gest.count        = count_q;
    assign gest.hold_release = hold_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    gap_closes_a: assert property (valid_q |-> count_q != 3'h0 && $past(gap_q) == GW'(GAP_TICKS - 1) && !$past(btn))
        else $error("gesture closed without a full quiet window");
    hold_long_a: assert property (hold_q |-> $past(held_q) == HW'(HOLD_TICKS) && $past(btn_q) && !$past(btn))
        else $error("hold release reported before the hold time");
endmodule

// file: hdl/blsc_top.sv
// Power and operating state controller driven by one pushbutton and one LED.
`timescale 1ns/1ps
module blsc_top #(
    parameter int TICK_CYCLES        = blsc_pkg::TICK_CYCLES,
    parameter int AUTO_OFF_TICKS     = blsc_pkg::AUTO_OFF_TICKS,
    parameter int HOLD_TICKS         = blsc_pkg::HOLD_TICKS,
    parameter int GAP_TICKS          = blsc_pkg::GAP_TICKS,
    parameter int BOOT_TIMEOUT_TICKS = blsc_pkg::BOOT_TIMEOUT_TICKS
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        btn,
    input wire logic        boot_done,
    input wire logic        net_up,
    input wire logic        app_up,
    input wire logic        charger_in,
    input wire logic        batt_full,
    input wire logic        pair_done,
    output logic            led,
    output logic            power_en,
    output logic            sweep_allow,
    output logic            pair_start,
    output logic            unit_reset,
    output logic [2:0]      state
);
    localparam int TW = $clog2(TICK_CYCLES);
    localparam int AW = $clog2(AUTO_OFF_TICKS + 1);
    localparam int BW = $clog2(BOOT_TIMEOUT_TICKS + 1);

    if (TICK_CYCLES < 2 || AUTO_OFF_TICKS < 2 || BOOT_TIMEOUT_TICKS < 2)
    begin : g_check
        $error("blsc_top: tick, auto-off and boot counts must be at least two");
    end

    // True while the phase lies in the lit part of a repeating period.
    function automatic logic blink_on(input logic [11:0] phase, input logic [11:0] period,
                                      input logic [11:0] on_time);
        blink_on = (phase % period) < on_time;
    endfunction

    blsc_pkg::blsc_state_t state_q;
    blsc_pkg::blsc_state_t state_d;
    logic [TW-1:0]         tick_cnt_q;
    logic                  tick_q;
    logic [11:0]           phase_q;
    logic [AW-1:0]         pause_cnt_q;
    logic [BW-1:0]         boot_cnt_q;
    logic                  led_q;
    logic                  led_d;
    logic                  power_q;
    logic                  sweep_q;
    logic                  pair_start_q;
    logic                  unit_reset_q;

    blsc_gest_if gest_if ();

    blsc_gesture #(
        .HOLD_TICKS (HOLD_TICKS),
        .GAP_TICKS  (GAP_TICKS)
    ) u_gesture (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (tick_q),
        .btn     (btn),
        .gest    (gest_if.src)
    );

    wire single        = gest_if.valid && gest_if.count == blsc_pkg::CNT_SINGLE;
    wire triple        = gest_if.valid && gest_if.count == blsc_pkg::CNT_TRIPLE;
    wire fivex         = gest_if.valid && gest_if.count == blsc_pkg::CNT_PAIR;
    wire linked        = net_up && app_up;
    wire boot_expired  = tick_q && boot_cnt_q == BW'(BOOT_TIMEOUT_TICKS - 1);
    wire pause_expired = tick_q && pause_cnt_q == AW'(AUTO_OFF_TICKS - 1);

    // One-cycle enable every millisecond paces every timer and blink.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else if (tick_cnt_q == TW'(TICK_CYCLES - 1))
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + TW'(1);
            tick_q     <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_q <= 12'h000;
        else if (tick_q)
            phase_q <= (phase_q == blsc_pkg::PHASE_PERIOD - 12'h001) ? 12'h000 : phase_q + 12'h001;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            boot_cnt_q <= '0;
        else if (state_q != blsc_pkg::ST_BOOT)
            boot_cnt_q <= '0;
        else if (tick_q && !boot_expired)
            boot_cnt_q <= boot_cnt_q + BW'(1);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pause_cnt_q <= '0;
        else if (state_q != blsc_pkg::ST_PAUSED)
            pause_cnt_q <= '0;
        else if (tick_q && !pause_expired)
            pause_cnt_q <= pause_cnt_q + AW'(1);
    end

    // Hold and triple press outrank every state; off only answers a single press.
    always_comb
    begin
        state_d = state_q;
        if (state_q == blsc_pkg::ST_OFF)
        begin
            if (single)
                state_d = blsc_pkg::ST_BOOT;
        end
        else if (gest_if.hold_release)
            state_d = blsc_pkg::ST_BOOT;
        else if (triple)
            state_d = blsc_pkg::ST_OFF;
        else if (fivex)
            state_d = blsc_pkg::ST_PAIRING;
        else
        begin
            case (state_q)
                blsc_pkg::ST_BOOT:
                    if (boot_done)
                        state_d = blsc_pkg::ST_SEARCH;
                    else if (boot_expired)
                        state_d = blsc_pkg::ST_ERROR;
                blsc_pkg::ST_SEARCH:
                    if (linked)
                        state_d = blsc_pkg::ST_ENABLED;
                blsc_pkg::ST_ENABLED:
                    if (!linked)
                        state_d = blsc_pkg::ST_SEARCH;
                    else if (single)
                        state_d = blsc_pkg::ST_PAUSED;
                blsc_pkg::ST_PAUSED:
                    if (single)
                        state_d = linked ? blsc_pkg::ST_ENABLED : blsc_pkg::ST_SEARCH;
                    else if (pause_expired)
                        state_d = blsc_pkg::ST_OFF;
                blsc_pkg::ST_PAIRING:
                    if (pair_done)
                        state_d = blsc_pkg::ST_SEARCH;
                default:
                    state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= blsc_pkg::ST_OFF;
        else
            state_q <= state_d;
    end

    // LED pattern by state; in search a full battery on the charger shows steady in place of the slow flashing.
    always_comb
    begin
        led_d = 1'b0;
        case (state_q)
            blsc_pkg::ST_BOOT,
            blsc_pkg::ST_ERROR:
                led_d = blink_on(phase_q, blsc_pkg::RAPID_PERIOD, blsc_pkg::RAPID_ON);
            blsc_pkg::ST_SEARCH:
                if (charger_in)
                    led_d = batt_full || blink_on(phase_q, blsc_pkg::SLOW_PERIOD, blsc_pkg::SLOW_ON);
                else
                    led_d = blink_on(phase_q, blsc_pkg::SLOW_PERIOD, blsc_pkg::SLOW_ON);
            blsc_pkg::ST_ENABLED:
                led_d = 1'b1;
            blsc_pkg::ST_PAUSED:
                led_d = phase_q < blsc_pkg::VSLOW_ON;
            blsc_pkg::ST_PAIRING:
                led_d = phase_q < blsc_pkg::BURST_SPAN
                        && blink_on(phase_q, blsc_pkg::BURST_PERIOD, blsc_pkg::BURST_ON);
            default:
                led_d = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            led_q <= 1'b0;
        else
            led_q <= led_d;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_q      <= 1'b0;
            sweep_q      <= 1'b0;
            pair_start_q <= 1'b0;
            unit_reset_q <= 1'b0;
        end
        else
        begin
            power_q      <= state_d != blsc_pkg::ST_OFF;
            sweep_q      <= state_d == blsc_pkg::ST_ENABLED;
            pair_start_q <= state_d == blsc_pkg::ST_PAIRING && state_q != blsc_pkg::ST_PAIRING;
            unit_reset_q <= state_q != blsc_pkg::ST_OFF && gest_if.hold_release;
        end
    end

    assign led         = led_q;
    assign power_en    = power_q;
    assign sweep_allow = sweep_q;
    assign pair_start  = pair_start_q;
    assign unit_reset  = unit_reset_q;
    assign state       = state_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence single_s;
        gest_if.valid && gest_if.count == blsc_pkg::CNT_SINGLE;
    endsequence

    sequence triple_s;
        gest_if.valid && gest_if.count == blsc_pkg::CNT_TRIPLE && !gest_if.hold_release;
    endsequence

    off_power_on_a: assert property (state_q == blsc_pkg::ST_OFF ##0 single_s |=> state_q == blsc_pkg::ST_BOOT ##1 power_en)
        else $error("single press from off did not power on");
    boot_timeout_a: assert property (state_q == blsc_pkg::ST_BOOT && boot_expired && !boot_done && !gest_if.valid
                                     && !gest_if.hold_release |=> state_q == blsc_pkg::ST_ERROR)
        else $error("stuck boot did not reach error");
    search_led_a: assert property ($past(state_q == blsc_pkg::ST_SEARCH && !charger_in) |-> led_q
                                   == $past(blink_on(phase_q, blsc_pkg::SLOW_PERIOD, blsc_pkg::SLOW_ON)))
        else $error("search LED not slow flashing");
    enabled_led_a: assert property (state_q == blsc_pkg::ST_ENABLED [*2] |-> led_q && sweep_allow)
        else $error("enabled state without steady LED");
    pause_press_a: assert property (state_q == blsc_pkg::ST_ENABLED && linked ##0 single_s |=> state_q
                                    == blsc_pkg::ST_PAUSED && !sweep_allow)
        else $error("single press did not pause");
    pause_led_a: assert property ($past(state_q == blsc_pkg::ST_PAUSED && phase_q >= blsc_pkg::VSLOW_ON) |-> !led_q)
        else $error("paused LED lit in the dark interval");
    auto_off_a: assert property (state_q == blsc_pkg::ST_PAUSED && pause_expired && !gest_if.valid
                                 && !gest_if.hold_release |=> state_q == blsc_pkg::ST_OFF ##1 !power_en)
        else $error("paused unit did not power off after timeout");
    paused_resume_a: assert property (state_q == blsc_pkg::ST_PAUSED && linked ##0 single_s |=> sweep_allow)
        else $error("single press did not resume from pause");
    triple_off_a: assert property (state_q != blsc_pkg::ST_OFF ##0 triple_s |=> state_q == blsc_pkg::ST_OFF)
        else $error("triple press did not power off");
    five_pair_a: assert property (state_q != blsc_pkg::ST_OFF && state_q != blsc_pkg::ST_PAIRING && fivex
                                  && !gest_if.hold_release |=> pair_start
                                  && state_q == blsc_pkg::ST_PAIRING)
        else $error("five presses did not start pairing");
    pair_led_a: assert property ($past(state_q == blsc_pkg::ST_PAIRING && phase_q >= blsc_pkg::BURST_SPAN) |-> !led_q)
        else $error("pairing LED lit during burst pause");
    hold_reset_a: assert property (state_q != blsc_pkg::ST_OFF && gest_if.hold_release |=> unit_reset
                                   && state_q == blsc_pkg::ST_BOOT)
        else $error("long hold did not reset the unit");
    lost_link_a: assert property (state_q == blsc_pkg::ST_ENABLED && !linked && !gest_if.valid
                                  && !gest_if.hold_release |=> state_q == blsc_pkg::ST_SEARCH)
        else $error("lost link did not return to search");
    charge_led_a: assert property ($past(state_q == blsc_pkg::ST_SEARCH && charger_in && batt_full) |-> led_q)
        else $error("full battery on charger not shown steady");
endmodule

// file: tb/blsc_operator.sv
// Behavioural operator who presses and holds the pushbutton.
`timescale 1ns/1ps
module blsc_operator (
    input wire logic sys_clk,
    output logic     btn
);
    initial btn = 1'h0;

    // Presses are two cycles down with four cycles up, well inside one gesture window.
    task automatic press(input int cnt);
        repeat (cnt)
        begin
            @(posedge sys_clk);
            btn <= 1'h1;
            repeat (2) @(posedge sys_clk);
            btn <= 1'h0;
            repeat (3) @(posedge sys_clk);
        end
    endtask

    task automatic hold(input int cycles);
        @(posedge sys_clk);
        btn <= 1'h1;
        repeat (cycles) @(posedge sys_clk);
        btn <= 1'h0;
    endtask
endmodule

// file: tb/blsc_bench.sv
// Self-checking bench for the button and LED state controller.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        compares = compares + 1; \
        if ((got) !== (exp)) \
        begin \
            error_cnt = error_cnt + 1; \
            $display("wrong value %s expected %0d seen %0d", what, exp, got); \
        end \
    end
module blsc_bench;
    localparam int TK   = 4;
    localparam int AUTO = 50;
    localparam int HOLD = 20;
    localparam int GAP  = 4;
    localparam int BOOT = 30;
    logic       sys_clk;
    logic       rst_n;
    logic       btn;
    logic       boot_done;
    logic       net_up;
    logic       app_up;
    logic       charger_in;
    logic       batt_full;
    logic       pair_done;
    logic       led;
    logic       power_en;
    logic       sweep_allow;
    logic       pair_start;
    logic       unit_reset;
    logic [2:0] state;
    int         error_cnt = 0;
    int         compares = 0;
    int         hi, lo, n;

    blsc_top #(
        .TICK_CYCLES        (TK),
        .AUTO_OFF_TICKS     (AUTO),
        .HOLD_TICKS         (HOLD),
        .GAP_TICKS          (GAP),
        .BOOT_TIMEOUT_TICKS (BOOT)
    ) dut_u (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .btn         (btn),
        .boot_done   (boot_done),
        .net_up      (net_up),
        .app_up      (app_up),
        .charger_in  (charger_in),
        .batt_full   (batt_full),
        .pair_done   (pair_done),
        .led         (led),
        .power_en    (power_en),
        .sweep_allow (sweep_allow),
        .pair_start  (pair_start),
        .unit_reset  (unit_reset),
        .state       (state)
    );

    blsc_operator op_u (
        .sys_clk (sys_clk),
        .btn     (btn)
    );

    initial
    begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Outputs are sampled on the falling edge, clear of the registers' updates.
    task automatic step();
        @(negedge sys_clk);
        n = n + 1;
    endtask

    task automatic wait_state(input blsc_pkg::blsc_state_t exp, input int bound);
        n = 0;
        while (state !== exp && n < bound) step();
        `CHK("state", exp, state);
        if (state !== exp) print_verdict();
    endtask

    // Counts the cycles in which the state holds and, if asked, the LED stays lit.
    task automatic stay(input blsc_pkg::blsc_state_t exp, input bit lit, input int cycles);
        hi = 0;
        repeat (cycles)
        begin
            step();
            hi = hi + ((state === exp && (!lit || led === 1'h1)) ? 1 : 0);
        end
        `CHK("state_and_led_held", cycles, hi);
    endtask

    // Measures one lit span and the dark span after it, in cycles.
    task automatic measure_led();
        n = 0;
        while (led !== 1'h0 && n < 20000) step();
        while (led !== 1'h1 && n < 20000) step();
        hi = n;
        while (led === 1'h1 && n < 20000) step();
        hi = n - hi;
        lo = n;
        while (led === 1'h0 && n < 20000) step();
        lo = n - lo;
        `CHK("led_edges_seen", 1'h1, n < 20000);
        if (n >= 20000) print_verdict();
    endtask

    task automatic power_up();
        op_u.press(1);
        wait_state(blsc_pkg::ST_ENABLED, 100);
    endtask

    task automatic t_boot_error();
        op_u.press(1);
        wait_state(blsc_pkg::ST_BOOT, 100);
        `CHK("power_en", 1'h1, power_en);
        wait_state(blsc_pkg::ST_ERROR, 200);
        measure_led();
        `CHK("rapid_on", int'(blsc_pkg::RAPID_ON) * TK, hi);
        `CHK("rapid_off", int'(blsc_pkg::RAPID_PERIOD - blsc_pkg::RAPID_ON) * TK, lo);
        op_u.press(1);
        stay(blsc_pkg::ST_ERROR, 1'b0, 60);
        op_u.press(3);
        wait_state(blsc_pkg::ST_OFF, 100);
        `CHK("power_en", 1'h0, power_en);
    endtask

    task automatic t_connect();
        @(posedge sys_clk);
        boot_done <= 1'h1;
        op_u.press(1);
        wait_state(blsc_pkg::ST_SEARCH, 100);
        measure_led();
        `CHK("slow_on", int'(blsc_pkg::SLOW_ON) * TK, hi);
        `CHK("slow_off", int'(blsc_pkg::SLOW_PERIOD - blsc_pkg::SLOW_ON) * TK, lo);
        @(posedge sys_clk);
        net_up <= 1'h1;
        app_up <= 1'h1;
        wait_state(blsc_pkg::ST_ENABLED, 10);
        `CHK("sweep_allow", 1'h1, sweep_allow);
        stay(blsc_pkg::ST_ENABLED, 1'b1, 300);
    endtask

    task automatic t_pause();
        op_u.press(1);
        wait_state(blsc_pkg::ST_PAUSED, 100);
        `CHK("sweep_allow", 1'h0, sweep_allow);
        op_u.press(1);
        wait_state(blsc_pkg::ST_ENABLED, 100);
        op_u.press(2);
        stay(blsc_pkg::ST_ENABLED, 1'b1, 60);
        op_u.press(1);
        wait_state(blsc_pkg::ST_PAUSED, 100);
        n = 0;
        while (state !== blsc_pkg::ST_OFF && n < 400) step();
        `CHK("auto_off_in_time", 1'h1, n >= AUTO * TK - 8 && n <= AUTO * TK + 8);
        `CHK("power_en", 1'h0, power_en);
        if (n >= 400) print_verdict();
    endtask

    task automatic t_paused_off();
        power_up();
        op_u.press(1);
        wait_state(blsc_pkg::ST_PAUSED, 100);
        op_u.press(3);
        wait_state(blsc_pkg::ST_OFF, 100);
    endtask

    task automatic t_pair();
        power_up();
        op_u.press(5);
        n = 0;
        while (pair_start !== 1'h1 && n < 100) step();
        `CHK("pair_start", 1'h1, pair_start);
        `CHK("state", blsc_pkg::ST_PAIRING, state);
        if (n >= 100) print_verdict();
        measure_led();
        `CHK("burst_on", int'(blsc_pkg::BURST_ON) * TK, hi);
        @(posedge sys_clk);
        pair_done <= 1'h1;
        wait_state(blsc_pkg::ST_ENABLED, 10);
        @(posedge sys_clk);
        pair_done <= 1'h0;
    endtask

    task automatic t_link();
        @(posedge sys_clk);
        charger_in <= 1'h1;
        batt_full  <= 1'h1;
        app_up     <= 1'h0;
        wait_state(blsc_pkg::ST_SEARCH, 10);
        stay(blsc_pkg::ST_SEARCH, 1'b1, 300);
        @(posedge sys_clk);
        batt_full <= 1'h0;
        measure_led();
        `CHK("charge_on", int'(blsc_pkg::SLOW_ON) * TK, hi);
        `CHK("charge_off", int'(blsc_pkg::SLOW_PERIOD - blsc_pkg::SLOW_ON) * TK, lo);
        @(posedge sys_clk);
        charger_in <= 1'h0;
    endtask

    task automatic t_hold();
        op_u.hold((HOLD + 5) * TK);
        n = 0;
        while (unit_reset !== 1'h1 && n < 20) step();
        `CHK("unit_reset", 1'h1, unit_reset);
        `CHK("state", blsc_pkg::ST_BOOT, state);
        if (n >= 20) print_verdict();
        wait_state(blsc_pkg::ST_SEARCH, 10);
        stay(blsc_pkg::ST_SEARCH, 1'b0, 60);
    endtask

    task automatic t_triple();
        @(posedge sys_clk);
        app_up <= 1'h1;
        wait_state(blsc_pkg::ST_ENABLED, 10);
        op_u.press(3);
        wait_state(blsc_pkg::ST_OFF, 100);
        `CHK("power_en", 1'h0, power_en);
    endtask

    initial
    begin
        rst_n = 1'h0;
        boot_done = 1'h0;
        net_up = 1'h0;
        app_up = 1'h0;
        charger_in = 1'h0;
        batt_full = 1'h0;
        pair_done = 1'h0;
        repeat (20) @(posedge sys_clk);
        `CHK("reset_outputs", 8'h00, {led, power_en, sweep_allow, pair_start, unit_reset, state});
        rst_n <= 1'h1;
        t_boot_error();
        t_connect();
        t_pause();
        t_paused_off();
        t_pair();
        t_link();
        t_hold();
        t_triple();
        print_verdict();
    end
endmodule
